/* File: hdl/sds_cfg.svh */
// Constants for the serdes parallel-side control block
// Operation
// - Wrap enable loops transmit stream into receiver
// - Wrap holds both serial outputs at one
// - Two byte clocks, half word rate, opposite phase
// - Received words alternate between the byte clocks
// - Comma word appears on clock A rising
// - Reference clock times ten serial bits
// - One transmit word captured per reference cycle
// - Receiver locks using the reference clock
// - Earliest received bit lands in bit zero
// - Transmit bit zero first, least significant
// - Lost signal forces received word all ones
// - Signal present follows input amplitude detector, or wrap enable
// - Frequency lock bounded, phase lock follows
// - Comma pulse only while alignment enabled
// - Alignment disabled: no realign, no pulse
`ifndef SDS_CFG_SVH
`define SDS_CFG_SVH

`define SDS_WORD_BITS        10
`define SDS_ALL_ONES         10'h3ff
`define SDS_COMMA_MASK       10'h07f
`define SDS_COMMA_VALUE      10'h07c

`define SDS_CLK_HZ           100000000
`define SDS_FREQ_LOCK_MS     500
`define SDS_FREQ_LOCK_CYCLES ((`SDS_CLK_HZ / 1000) * `SDS_FREQ_LOCK_MS)
`define SDS_BIT_CYCLES       1
`define SDS_PHASE_LOCK_BITS  2500
`define SDS_PHASE_LOCK_CYCLES (`SDS_PHASE_LOCK_BITS * `SDS_BIT_CYCLES)
`define SDS_LOCK_CONFIRM     8

`define SDS_ADDR_IRQ_STATUS  8'h00
`define SDS_ADDR_IRQ_MASK    8'h04
`define SDS_ADDR_LINK_STATE  8'h08
`define SDS_ADDR_LAST_WORD   8'h0c
`define SDS_ADDR_CTRL        8'h10

`define SDS_IRQ_COMMA        0
`define SDS_IRQ_SIG_LOST     1
`define SDS_IRQ_LOCKED       2
`define SDS_IRQ_TIMEOUT      3
`define SDS_IRQ_BITS         4
`define SDS_MASK_RESET       4'h0
`define SDS_CTRL_RESET       1'b0

`define SDS_RESP_OKAY        2'b00
`define SDS_RESP_SLVERR      2'b10

`endif

/* File: hdl/sds_pkg.sv */
// Types shared by the serdes parallel-side control block
package sds_pkg;
   typedef logic [9:0] sds_word_t;
   typedef enum logic [1:0] {LOCK_SEARCH, LOCK_FREQ, LOCK_PHASE} sds_lock_e;
endpackage : sds_pkg

/* File: hdl/sds_pin_sync.sv */
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module sds_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinOut
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;

   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         pinOut <= '0;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
         // A bit changes only once two stages agree
         pinOut <= (stage3 & agree) | (pinOut & ~agree);
      end
   end
endmodule : sds_pin_sync

/* File: hdl/sds_serializer.sv */
// Transmit shift register, one serial bit per clock
`timescale 1ns/1ps
`include "sds_cfg.svh"
module sds_serializer
   import sds_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              load,
   input  wire sds_pkg::sds_word_t word,
   output logic                   serialBit
);
   sds_word_t shiftReg;

   assign serialBit = shiftReg[0];

   always_ff @(posedge clk) begin
      if (rst) begin
         shiftReg <= `SDS_ALL_ONES;
      end else if (load) begin
         shiftReg <= word;
      end else begin
         shiftReg <= {1'b1, shiftReg[9:1]};
      end
   end
endmodule : sds_serializer

/* File: hdl/sds_parallel_ctrl.sv */
// Serdes parallel side: word intake, deserialiser, comma alignment, lock, registers
`timescale 1ns/1ps
`include "sds_cfg.svh"
module sds_parallel_ctrl #(
   parameter int FREQ_LOCK_CYCLES = `SDS_FREQ_LOCK_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              referenceByteClock,
   input  wire sds_pkg::sds_word_t txWord,
   input  wire logic              serialWrapEnable,
   input  wire logic              commaAlignEnable,
   input  wire logic              serialIn,
   input  wire logic              lineAmplitudeOk,
   output logic                   serialOutP,
   output logic                   serialOutN,
   output sds_pkg::sds_word_t     rxWord,
   output logic                   recoveredByteClockA,
   output logic                   recoveredByteClockB,
   output logic                   commaSeen,
   output logic                   signalPresent,
   output logic                   rxLocked,
   output logic                   irq,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   import sds_pkg::*;

   function automatic logic isComma(input sds_word_t w);
      return (w & `SDS_COMMA_MASK) == `SDS_COMMA_VALUE;
   endfunction : isComma

   function automatic logic isMapped(input logic [7:0] a);
      return a == `SDS_ADDR_IRQ_STATUS || a == `SDS_ADDR_IRQ_MASK ||
             a == `SDS_ADDR_LINK_STATE || a == `SDS_ADDR_LAST_WORD ||
             a == `SDS_ADDR_CTRL;
   endfunction : isMapped

   // Pin synchronisers
   logic      [13:0] pinRaw;
   logic      [13:0] pinSync;
   logic      [2:0]  serialStage;
   logic             refSync;
   logic             wrapPin;
   logic             alignEnable;
   logic             serialInSync;
   logic             amplitudeOk;
   sds_word_t        txWordSync;

   assign pinRaw = {referenceByteClock, serialWrapEnable, commaAlignEnable,
                    lineAmplitudeOk, txWord};

   sds_pin_sync #(.WIDTH(14)) pinSyncInst (
      .clk    (clk),
      .rst    (rst),
      .pinIn  (pinRaw),
      .pinOut (pinSync)
   );

   assign refSync      = pinSync[13];
   assign wrapPin      = pinSync[12];
   assign alignEnable  = pinSync[11];
   assign amplitudeOk  = pinSync[10];
   assign txWordSync   = pinSync[9:0];
   assign serialInSync = serialStage[2];

   // Serial bits last one clock, too short for the agreement filter
   always_ff @(posedge clk) begin
      if (rst) begin
         serialStage <= 3'h7;
      end else begin
         serialStage <= {serialStage[1:0], serialIn};
      end
   end

   // Register state
   logic                     ctrlWrap;
   logic [`SDS_IRQ_BITS-1:0] irqStatus;
   logic [`SDS_IRQ_BITS-1:0] irqMask;
   logic [`SDS_IRQ_BITS-1:0] irqEvents;
   logic [`SDS_IRQ_BITS-1:0] irqClear;
   logic                     wrapActive;

   assign wrapActive = wrapPin | ctrlWrap;

   // Transmit word intake on reference clock rising edge
   logic refPrev;
   logic refRise;
   logic txBit;

   assign refRise = refSync & ~refPrev;

   always_ff @(posedge clk) begin
      if (rst) begin
         refPrev <= 1'b0;
      end else begin
         refPrev <= refSync;
      end
   end

   sds_serializer serInst (
      .clk       (clk),
      .rst       (rst),
      .load      (refRise),
      .word      (txWordSync),
      .serialBit (txBit)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         serialOutP <= 1'b1;
         serialOutN <= 1'b1;
      end else if (wrapActive) begin
         serialOutP <= 1'b1;
         serialOutN <= 1'b1;
      end else begin
         serialOutP <= txBit;
         serialOutN <= ~txBit;
      end
   end

   // Receive bit source and signal detect
   logic rxBit;
   logic signalPrev;

   assign rxBit = wrapActive ? txBit : serialInSync;

   always_ff @(posedge clk) begin
      if (rst) begin
         signalPresent <= 1'b0;
         signalPrev    <= 1'b0;
      end else begin
         signalPresent <= wrapActive | amplitudeOk;
         signalPrev    <= signalPresent;
      end
   end

   // Reference period check and lock sequence
   logic [7:0]  periodCount;
   logic        periodGood;
   logic [3:0]  goodRun;
   logic [31:0] lockTimer;
   logic [31:0] phaseTimer;
   logic        lockTimeout;
   sds_lock_e   lockState;

   assign periodGood = periodCount == 8'(`SDS_WORD_BITS - 1);

   always_ff @(posedge clk) begin
      if (rst) begin
         periodCount <= '0;
         goodRun     <= '0;
      end else if (refRise) begin
         periodCount <= '0;
         if (!periodGood) begin
            goodRun <= '0;
         end else if (goodRun != 4'(`SDS_LOCK_CONFIRM)) begin
            goodRun <= goodRun + 4'd1;
         end
      end else if (periodCount != 8'hff) begin
         periodCount <= periodCount + 8'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lockState   <= LOCK_SEARCH;
         lockTimer   <= '0;
         phaseTimer  <= '0;
         lockTimeout <= 1'b0;
      end else begin
         lockTimeout <= 1'b0;
         case (lockState)
            LOCK_SEARCH: begin
               phaseTimer <= '0;
               if (goodRun == 4'(`SDS_LOCK_CONFIRM)) begin
                  lockState <= LOCK_FREQ;
                  lockTimer <= '0;
               end else if (lockTimer == 32'(FREQ_LOCK_CYCLES - 1)) begin
                  lockTimeout <= 1'b1;
                  lockTimer   <= '0;
               end else begin
                  lockTimer <= lockTimer + 32'd1;
               end
            end
            LOCK_FREQ: begin
               if (refRise && !periodGood) begin
                  lockState <= LOCK_SEARCH;
               end else if (!signalPresent) begin
                  phaseTimer <= '0;
               end else if (phaseTimer == 32'(`SDS_PHASE_LOCK_CYCLES - 1)) begin
                  lockState <= LOCK_PHASE;
               end else begin
                  phaseTimer <= phaseTimer + 32'd1;
               end
            end
            LOCK_PHASE: begin
               phaseTimer <= '0;
               if (refRise && !periodGood) begin
                  lockState <= LOCK_SEARCH;
               end else if (!signalPresent) begin
                  lockState <= LOCK_FREQ;
               end
            end
            default: begin
               lockState <= LOCK_SEARCH;
            end
         endcase
      end
   end

   assign rxLocked = lockState == LOCK_PHASE;

   // Deserialiser and comma alignment
   sds_word_t rxShift;
   sds_word_t nextShift;
   sds_word_t pendWord;
   logic [3:0] bitCount;
   logic       commaHit;
   logic       wordDone;
   logic       pending;

   assign nextShift = {rxBit, rxShift[9:1]};
   assign commaHit  = alignEnable & isComma(nextShift);
   assign wordDone  = (bitCount == 4'(`SDS_WORD_BITS - 1)) | commaHit;

   always_ff @(posedge clk) begin
      if (rst) begin
         rxShift  <= `SDS_ALL_ONES;
         bitCount <= '0;
      end else begin
         rxShift  <= nextShift;
         bitCount <= wordDone ? 4'd0 : bitCount + 4'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rxWord              <= `SDS_ALL_ONES;
         recoveredByteClockA <= 1'b0;
         recoveredByteClockB <= 1'b1;
         pendWord            <= `SDS_ALL_ONES;
         pending             <= 1'b0;
      end else begin
         if (pending) begin
            rxWord              <= signalPresent ? pendWord : `SDS_ALL_ONES;
            recoveredByteClockA <= 1'b1;
            recoveredByteClockB <= 1'b0;
            pending             <= 1'b0;
         end else if (wordDone && commaHit && recoveredByteClockA) begin
            // Clock A must fall before it can rise with the comma word
            recoveredByteClockA <= 1'b0;
            recoveredByteClockB <= 1'b1;
            pendWord            <= nextShift;
            pending             <= 1'b1;
         end else if (wordDone) begin
            rxWord              <= signalPresent ? nextShift : `SDS_ALL_ONES;
            recoveredByteClockA <= ~recoveredByteClockA;
            recoveredByteClockB <= recoveredByteClockA;
         end else if (!signalPresent) begin
            rxWord <= `SDS_ALL_ONES;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         commaSeen <= 1'b0;
      end else begin
         commaSeen <= wordDone & commaHit;
      end
   end

   // Interrupt events
   logic lockedPrev;

   always_ff @(posedge clk) begin
      if (rst) begin
         lockedPrev <= 1'b0;
      end else begin
         lockedPrev <= rxLocked;
      end
   end

   always_comb begin
      irqEvents                   = '0;
      irqEvents[`SDS_IRQ_COMMA]   = commaSeen;
      irqEvents[`SDS_IRQ_SIG_LOST] = signalPrev & ~signalPresent;
      irqEvents[`SDS_IRQ_LOCKED]  = rxLocked & ~lockedPrev;
      irqEvents[`SDS_IRQ_TIMEOUT] = lockTimeout;
   end

   assign irq = |(irqStatus & irqMask);

   // AXI4-Lite write channel
   logic [7:0]  awAddr;
   logic        awHeld;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic        wHeld;
   logic        doWrite;

   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
   assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         awAddr <= '0;
         awHeld <= 1'b0;
         wData  <= '0;
         wStrb  <= '0;
         wHeld  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
            awHeld <= 1'b1;
         end else if (doWrite) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            wHeld <= 1'b1;
         end else if (doWrite) begin
            wHeld <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SDS_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= isMapped(awAddr) ? `SDS_RESP_OKAY : `SDS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign irqClear = (doWrite && awAddr == `SDS_ADDR_IRQ_STATUS && wStrb[0]) ?
                     wData[`SDS_IRQ_BITS-1:0] : '0;

   always_ff @(posedge clk) begin
      if (rst) begin
         irqStatus <= '0;
      end else begin
         // A new event outweighs a clear in the same cycle
         irqStatus <= (irqStatus & ~irqClear) | irqEvents;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqMask  <= `SDS_MASK_RESET;
         ctrlWrap <= `SDS_CTRL_RESET;
      end else if (doWrite && wStrb[0]) begin
         if (awAddr == `SDS_ADDR_IRQ_MASK) begin
            irqMask <= wData[`SDS_IRQ_BITS-1:0];
         end else if (awAddr == `SDS_ADDR_CTRL) begin
            ctrlWrap <= wData[0];
         end
      end
   end

   // AXI4-Lite read channel
   logic [31:0] readValue;

   always_comb begin
      readValue = '0;
      if (s_axi_araddr == `SDS_ADDR_IRQ_STATUS) begin
         readValue = 32'(irqStatus);
      end else if (s_axi_araddr == `SDS_ADDR_IRQ_MASK) begin
         readValue = 32'(irqMask);
      end else if (s_axi_araddr == `SDS_ADDR_LINK_STATE) begin
         readValue = {26'h000_0000, wrapActive, alignEnable, lockState, rxLocked,
                      signalPresent};
      end else if (s_axi_araddr == `SDS_ADDR_LAST_WORD) begin
         readValue = 32'(rxWord);
      end else if (s_axi_araddr == `SDS_ADDR_CTRL) begin
         readValue = 32'(ctrlWrap);
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `SDS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= readValue;
         s_axi_rresp  <= isMapped(s_axi_araddr) ? `SDS_RESP_OKAY : `SDS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : sds_parallel_ctrl

/* File: tb/sds_ctrl_properties.sv */
// Concurrent properties of the serdes parallel-side control block
`timescale 1ns/1ps
`include "sds_cfg.svh"
module sds_ctrl_chk
   import sds_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               serialWrapEnable,
   input wire logic               commaAlignEnable,
   input wire logic               lineAmplitudeOk,
   input wire logic               serialOutP,
   input wire logic               serialOutN,
   input wire sds_pkg::sds_word_t rxWord,
   input wire logic               recoveredByteClockA,
   input wire logic               recoveredByteClockB,
   input wire logic               commaSeen,
   input wire logic               signalPresent,
   input wire logic               rxLocked,
   input wire logic               irq
);
   import sds_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic commaWord;
   assign commaWord = (rxWord & `SDS_COMMA_MASK) == `SDS_COMMA_VALUE;

   AST_WRAP_OUT_HIGH: assert property (
      serialWrapEnable [*6] |-> serialOutP && serialOutN) else $error("outputs low in wrap");
   AST_OUT_DIFF: assert property (
      !serialWrapEnable [*6] |-> serialOutN != serialOutP) else $error("output pair not complementary");
   AST_LOS_ONES: assert property (
      (!serialWrapEnable && !lineAmplitudeOk) [*8] |-> rxWord == `SDS_ALL_ONES)
      else $error("received word not all ones without signal");
   AST_SIG_PRESENT: assert property (
      (serialWrapEnable || lineAmplitudeOk) [*7] |-> signalPresent) else $error("signal not present");
   AST_SIG_ABSENT: assert property (
      (!serialWrapEnable && !lineAmplitudeOk) [*6] |-> !signalPresent) else $error("signal present");
   AST_CLK_OPPOSITE: assert property (
      recoveredByteClockA != recoveredByteClockB) else $error("byte clocks in phase");
   AST_WORD_ON_EDGE: assert property (
      signalPresent && $past(signalPresent) && $changed(rxWord)
      |-> $rose(recoveredByteClockA) || $rose(recoveredByteClockB)) else $error("word off clock edge");
   AST_COMMA_ON_A: assert property (
      commaSeen |-> ($rose(recoveredByteClockA) && commaWord) or
                    (##1 ($rose(recoveredByteClockA) && commaWord)))
      else $error("comma word not on clock A");
   AST_NO_PULSE_OFF: assert property (
      !commaAlignEnable [*8] |-> !commaSeen) else $error("comma pulse while disabled");
   AST_PULSE_SINGLE: assert property (
      commaSeen |=> !commaSeen) else $error("comma pulse too long");

   AST_COV_COMMA: cover property (commaSeen);
   AST_COV_LOCK: cover property ($rose(rxLocked));
   AST_COV_IRQ: cover property ($rose(irq));
   AST_COV_WRAP: cover property (serialWrapEnable && $rose(recoveredByteClockA));
endmodule : sds_ctrl_chk

bind sds_parallel_ctrl sds_ctrl_chk u_chk (
   .clk, .rst, .serialWrapEnable, .commaAlignEnable, .lineAmplitudeOk, .serialOutP,
   .serialOutN, .rxWord, .recoveredByteClockA, .recoveredByteClockB, .commaSeen,
   .signalPresent, .rxLocked, .irq
);

/* File: tb/sds_host_model.sv */
// Host model: free-running reference byte clock and transmit word source
`timescale 1ns/1ps
module sds_host_model
   import sds_pkg::*;
(
   input  wire logic               clk,
   input  wire sds_pkg::sds_word_t word,
   output logic                    referenceByteClock,
   output sds_pkg::sds_word_t      txWord
);
   import sds_pkg::*;
   logic [3:0] phase;

   initial begin
      phase  = 4'h0;
      txWord = 10'h3ff;
   end

   // Ten bit times per reference period
   always @(posedge clk) begin
      phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
   end
   assign referenceByteClock = (phase < 4'h5);

   // Coded word changes mid-low so it is steady around the rising edge
   always @(posedge clk) begin
      if (phase == 4'h7) begin
         txWord <= word;
      end
   end
endmodule : sds_host_model

/* File: tb/tb.sv */
// Self-checking testbench for the serdes parallel-side control block
`timescale 1ns/1ps
`include "sds_cfg.svh"
`define TB_CHK(act, exp) \
   begin \
      compares++; \
      if ((act) !== (exp)) begin \
         miscompares++; \
         $display("mismatch at %0t: got %h expected %h", $time, (act), (exp)); \
      end \
   end
module tb;
   import sds_pkg::*;
   localparam int LIMIT = 6000;
   logic        clk, rst, serialWrapEnable, commaAlignEnable, serialIn, lineAmplitudeOk;
   logic        referenceByteClock, serialOutP, serialOutN, recoveredByteClockA;
   logic        recoveredByteClockB, commaSeen, signalPresent, rxLocked, irq;
   sds_word_t   txWord, rxWord, hostWord;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          compares, miscompares, cycles, n;

   // Cable loops the serial output back to the input
   assign serialIn = serialOutP;
   always #5 clk = ~clk;

   sds_parallel_ctrl #(.FREQ_LOCK_CYCLES(2000)) u_dut (
      .clk, .rst, .referenceByteClock, .txWord, .serialWrapEnable, .commaAlignEnable,
      .serialIn, .lineAmplitudeOk, .serialOutP, .serialOutN, .rxWord, .recoveredByteClockA,
      .recoveredByteClockB, .commaSeen, .signalPresent, .rxLocked, .irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   sds_host_model u_host (.clk, .word(hostWord), .referenceByteClock, .txWord);

   task automatic stop_test();
      if (miscompares == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // Holds a word for exactly one reference period
   task automatic put_word(input sds_word_t w);
      hostWord <= w;
      repeat (10) @(posedge clk);
   endtask : put_word

   task automatic send_seq();
      put_word(`SDS_COMMA_VALUE);
      put_word(10'h2b5);
      put_word(10'h3ff);
   endtask : send_seq

   task automatic tx_check(input sds_word_t w);
      sds_word_t got;
      int        k;
      k = 0;
      fork
         begin
            put_word(w);
            put_word(10'h3ff);
         end
         begin
            while (serialOutP !== 1'b0 && k < 40) begin
               tick();
               k++;
            end
            for (int i = 0; i < 10; i++) begin
               got[i] = serialOutP;
               tick();
            end
         end
      join
      `TB_CHK(got, w)
   endtask : tx_check

   // Words are trusted only once a comma has aligned them
   task automatic rx_check();
      int k;
      k = 0;
      fork
         send_seq();
         begin
            while (commaSeen !== 1'b1 && k < 80) begin
               tick();
               k++;
            end
            tick();
            `TB_CHK({recoveredByteClockA, rxWord}, {1'b1, `SDS_COMMA_VALUE})
            while (recoveredByteClockB !== 1'b1 && k < 120) begin
               tick();
               k++;
            end
            `TB_CHK(rxWord, 10'h2b5)
         end
      join
   endtask : rx_check

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      serialWrapEnable = 1'b0;
      commaAlignEnable = 1'b1;
      lineAmplitudeOk = 1'b1;
      hostWord = 10'h3ff;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      compares = 0;
      miscompares = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      #1;
      `TB_CHK({serialOutP, serialOutN, rxWord}, {2'b11, `SDS_ALL_ONES})
      `TB_CHK({recoveredByteClockA, recoveredByteClockB, irq}, 3'b010)
      @(posedge clk);
      rst <= 1'b0;
      axi_read(`SDS_ADDR_IRQ_MASK);
      `TB_CHK({rsp, rd}, {`SDS_RESP_OKAY, 32'h0000_0000})
      axi_read(8'h20);
      `TB_CHK({rsp, rd}, {`SDS_RESP_SLVERR, 32'h0000_0000})
      axi_write(8'h20, 32'h0000_000f, 4'hf);
      `TB_CHK(rsp, `SDS_RESP_SLVERR)
      axi_write(`SDS_ADDR_IRQ_MASK, 32'h0000_000f, 4'he);
      axi_write(`SDS_ADDR_IRQ_MASK, 32'h0000_0004, 4'hf);
      axi_read(`SDS_ADDR_IRQ_MASK);
      `TB_CHK(rd, 32'h0000_0004)
      tx_check(10'h2f4);
      rx_check();
      repeat (2700) @(posedge clk);
      #1;
      `TB_CHK({rxLocked, irq}, 2'b11)
      axi_read(`SDS_ADDR_IRQ_STATUS);
      `TB_CHK(rd[`SDS_IRQ_LOCKED], 1'b1)
      axi_write(`SDS_ADDR_IRQ_MASK, 32'h0000_0000, 4'hf);
      tick();
      `TB_CHK(irq, 1'b0)
      axi_write(`SDS_ADDR_IRQ_MASK, 32'h0000_0004, 4'hf);
      tick();
      `TB_CHK(irq, 1'b1)
      axi_write(`SDS_ADDR_IRQ_STATUS, 32'h0000_0004, 4'hf);
      tick();
      `TB_CHK(irq, 1'b0)
      serialWrapEnable <= 1'b1;
      lineAmplitudeOk <= 1'b0;
      repeat (8) tick();
      rx_check();
      `TB_CHK({serialOutP, serialOutN, signalPresent}, 3'b111)
      commaAlignEnable <= 1'b0;
      repeat (8) tick();
      n = 0;
      fork
         send_seq();
         repeat (60) begin
            tick();
            if (commaSeen !== 1'b0) n++;
         end
      join
      `TB_CHK(n, 0)
      serialWrapEnable <= 1'b0;
      repeat (10) tick();
      `TB_CHK({signalPresent, rxWord}, {1'b0, `SDS_ALL_ONES})
      axi_read(`SDS_ADDR_LINK_STATE);
      `TB_CHK(rd, 32'h0000_0004)
      axi_read(`SDS_ADDR_LAST_WORD);
      `TB_CHK(rd, 32'h0000_03ff)
      stop_test();
   end
endmodule : tb
